// *** sstx_slot_map.sv ***
// Purpose: channel 6/7 source select and slot placement for the secondary serial port
// Assumes: slot strobes and sample inputs are synchronous to mclk_i
// Notes: channel 8 register is storage only; its source is handled elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "sstx_defines.svh"

module sstx_slot_map
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // frame position
  input wire logic slot_strobe_i,
  input wire logic frame_tdm_i,
  input wire logic [4:0] slot_index_i,
  input wire logic right_half_i,
  // sample sources
  input wire logic [31:0] loopback_two_i,
  input wire logic [31:0] echo_ref_two_i,
  input wire logic [15:0] echo_reference_one_half_word_i,
  input wire logic [15:0] echo_reference_two_half_word_i,
  // transmit word
  output logic [31:0] tx_word_o,
  output logic tx_drive_o,
  output logic tx_valid_o
);

  logic [7:0] ch6_r, ch6_nxt;
  logic [7:0] ch7_r, ch7_nxt;
  logic [7:0] ch8_r, ch8_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [31:0] word_r, word_nxt;
  logic drive_r, drive_nxt;
  logic valid_r, valid_nxt;
  sstx_pkg::sstx_slot_t eff_slot;
  sstx_pkg::sstx_src_e src6, src7;
  logic hit6, hit7;

  assign src6 = sstx_pkg::sstx_src_e'(ch6_r[`SSTX_SRC_MSB:`SSTX_SRC_LSB]);
  assign src7 = sstx_pkg::sstx_src_e'(ch7_r[`SSTX_SRC_MSB:`SSTX_SRC_LSB]);

  // in I2S/left-justified the half flag is the slot's top bit, so one compare serves both framings
  assign eff_slot = frame_tdm_i ? slot_index_i
                                : {right_half_i, slot_index_i[3:0]};
  assign hit6 = (eff_slot == ch6_r[`SSTX_SLOT_MSB:`SSTX_SLOT_LSB]);
  assign hit7 = (eff_slot == ch7_r[`SSTX_SLOT_MSB:`SSTX_SLOT_LSB]);

  // register state
  always_comb
  begin
    ch6_nxt = ch6_r;
    ch7_nxt = ch7_r;
    ch8_nxt = ch8_r;
    rdata_nxt = rdata_r;
    // reserved bits are masked off so a stray write cannot make them read back one
    if (reg_wr_i)
    begin
      if (reg_addr_i == `SSTX_OFF_CH6)
      begin
        ch6_nxt = reg_wdata_i & `SSTX_MASK_CH67;
      end
      else if (reg_addr_i == `SSTX_OFF_CH7)
      begin
        ch7_nxt = reg_wdata_i & `SSTX_MASK_CH67;
      end
      else if (reg_addr_i == `SSTX_OFF_CH8)
      begin
        ch8_nxt = reg_wdata_i & `SSTX_MASK_CH8;
      end
    end
    if (reg_rd_i)
    begin
      if (reg_addr_i == `SSTX_OFF_CH6)
      begin
        rdata_nxt = ch6_r;
      end
      else if (reg_addr_i == `SSTX_OFF_CH7)
      begin
        rdata_nxt = ch7_r;
      end
      else if (reg_addr_i == `SSTX_OFF_CH8)
      begin
        rdata_nxt = ch8_r;
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ch6_r <= `SSTX_RST_CH6;
      ch7_r <= `SSTX_RST_CH7;
      ch8_r <= `SSTX_RST_CH8;
      rdata_r <= 8'h00;
    end
    else
    begin
      ch6_r <= ch6_nxt;
      ch7_r <= ch7_nxt;
      ch8_r <= ch8_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

  // transmit word state
  always_comb
  begin
    word_nxt = word_r;
    drive_nxt = drive_r;
    valid_nxt = 1'b0;
    if (slot_strobe_i)
    begin
      valid_nxt = 1'b1;
      drive_nxt = 1'b0;
      word_nxt = 32'h0000_0000;
      // channel 6 wins a shared slot only with a loopback or echo code; reserved codes leave their channel undriven
      if (hit6 && (src6 == sstx_pkg::SSTX_SRC_LOOP || src6 == sstx_pkg::SSTX_SRC_ECHO))
      begin
        drive_nxt = 1'b1;
        word_nxt = (src6 == sstx_pkg::SSTX_SRC_LOOP) ? loopback_two_i : echo_ref_two_i;
      end
      else if (hit7 && src7 == sstx_pkg::SSTX_SRC_ECHO)
      begin
        drive_nxt = 1'b1;
        word_nxt = {echo_reference_one_half_word_i, echo_reference_two_half_word_i};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_r <= 32'h0000_0000;
      drive_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      word_r <= word_nxt;
      drive_r <= drive_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign tx_word_o = word_r;
  assign tx_drive_o = drive_r;
  assign tx_valid_o = valid_r;

  // checks
  ch6_loop_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && hit6 && src6 == sstx_pkg::SSTX_SRC_LOOP
    |=> tx_drive_o && tx_valid_o && tx_word_o == $past(loopback_two_i))
    else $error("channel 6 loopback word not sent");

  ch6_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && hit6 && (src6 == sstx_pkg::SSTX_SRC_OFF || src6 == sstx_pkg::SSTX_SRC_RSVD) && !hit7
    |=> !tx_drive_o)
    else $error("channel 6 drove while off or reserved");

  right_half_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && !frame_tdm_i && right_half_i && ch6_r[4] && slot_index_i[3:0] == ch6_r[3:0]
    && src6 == sstx_pkg::SSTX_SRC_ECHO
    |=> tx_drive_o && tx_word_o == $past(echo_ref_two_i))
    else $error("right half slot not placed");

  ch6_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == `SSTX_OFF_CH6
    |=> ch6_r[4:0] == $past(reg_wdata_i[4:0]) && !ch6_r[`SSTX_RSVD_BIT])
    else $error("channel 6 slot field not stored");

  ch6_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(reg_wr_i && reg_addr_i == `SSTX_OFF_CH6) |=> $stable(ch6_r))
    else $error("channel 6 register changed without a write");

  ch7_echo_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && hit7 && !hit6 && src7 == sstx_pkg::SSTX_SRC_ECHO
    |=> tx_drive_o && tx_word_o[31:16] == $past(echo_reference_one_half_word_i)
        && tx_word_o[15:0] == $past(echo_reference_two_half_word_i))
    else $error("channel 7 half-word pair wrong");

  ch7_reset_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(rst_i) |-> ch7_r == `SSTX_RST_CH7 && ch6_r == `SSTX_RST_CH6)
    else $error("slot reset values wrong");

  rsvd_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    reg_rd_i ##1 1'b1 |-> reg_rdata_o[`SSTX_RSVD_BIT] == 1'b0)
    else $error("reserved bit read as one");

  tdm_mid_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && frame_tdm_i && slot_index_i != ch6_r[4:0] && slot_index_i != ch7_r[4:0]
    |=> !tx_drive_o)
    else $error("unassigned slot driven");

  ch6_loop_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && hit6 && src6 == sstx_pkg::SSTX_SRC_LOOP);
  ch7_echo_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && hit7 && src7 == sstx_pkg::SSTX_SRC_ECHO);
  i2s_right_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    slot_strobe_i && !frame_tdm_i && right_half_i && drive_nxt);

endmodule

`default_nettype wire

// *** sstx_defines.svh ***
// Purpose: constants for the secondary serial port transmit slot map
// Assumes: 8-bit register port, 32-bit frame words
// Notes: offsets are the register addresses of the control port
`ifndef SSTX_DEFINES_SVH
`define SSTX_DEFINES_SVH

`define SSTX_OFF_CH6 8'h23
`define SSTX_OFF_CH7 8'h24
`define SSTX_OFF_CH8 8'h25

`define SSTX_RST_CH6 8'h05
`define SSTX_RST_CH7 8'h06
`define SSTX_RST_CH8 8'h07

`define SSTX_RSVD_BIT 7
`define SSTX_SRC_MSB 6
`define SSTX_SRC_LSB 5
`define SSTX_SLOT_MSB 4
`define SSTX_SLOT_LSB 0
`define SSTX_HALF_BIT 4

// writable bits: ch6/ch7 keep 6:0, ch8 keeps 5:0
`define SSTX_MASK_CH67 8'h7F
`define SSTX_MASK_CH8 8'h3F

`endif

// *** sstx_pkg.sv ***
// Purpose: types for the secondary serial port transmit slot map
// Assumes: nothing beyond the defines header
// Notes: source codes are per channel; reserved codes are treated as off
package sstx_pkg;

  typedef enum logic [1:0]
  {
    SSTX_SRC_OFF = 2'h0,
    SSTX_SRC_LOOP = 2'h1,
    SSTX_SRC_ECHO = 2'h2,
    SSTX_SRC_RSVD = 2'h3
  } sstx_src_e;

  typedef logic [4:0] sstx_slot_t;

endpackage

// *** sstx_host_model.sv ***
// Purpose: far-side sample source for the slot map bench
// Assumes: samples advance once per transmitted slot
// Notes: words change every slot so a stale capture is caught
`timescale 1ns/1ps
`default_nettype none
module sstx_host_model
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // slot handshake
  input wire logic tx_valid_i,
  // sample words
  output logic [31:0] loop_o,
  output logic [31:0] echo_o,
  output logic [15:0] half_one_o,
  output logic [15:0] half_two_o
);
  logic [7:0] seq_r;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      seq_r <= 8'h00;
    else if (tx_valid_i)
      seq_r <= seq_r + 8'h01;
  // each source distinct so a wrong mux leg shows
  assign loop_o = {4{seq_r ^ 8'hA5}};
  assign echo_o = {4{seq_r ^ 8'h3C}};
  assign half_one_o = {seq_r, 8'h11};
  assign half_two_o = {8'h22, seq_r};
endmodule
`default_nettype wire

// *** test_sstx_slot_map.sv ***
// Purpose: self-checking bench for the slot map
// Assumes: register port and slot strobes per hand-over timing
// Notes: expected words captured from the source model at the strobe edge
`timescale 1ns/1ps
`default_nettype none
module test_sstx_slot_map;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stb = 1'b0;
  logic tdm = 1'b1;
  logic rh = 1'b0;
  logic [4:0] idx = 5'h00;
  logic [7:0] rdata;
  logic [31:0] word, lp, ec;
  logic [15:0] h1, h2;
  logic drv, vld;
  int errors = 0;
  int tests_run = 0;
  always #4 mclk_i = ~mclk_i;
  sstx_slot_map u_sstx_slot_map (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .slot_strobe_i(stb), .frame_tdm_i(tdm),
    .slot_index_i(idx), .right_half_i(rh), .loopback_two_i(lp), .echo_ref_two_i(ec),
    .echo_reference_one_half_word_i(h1), .echo_reference_two_half_word_i(h2), .tx_word_o(word),
    .tx_drive_o(drv), .tx_valid_o(vld));
  sstx_host_model u_sstx_host_model (.mclk_i(mclk_i), .rst_i(rst_i), .tx_valid_i(vld), .loop_o(lp),
    .echo_o(ec), .half_one_o(h1), .half_two_o(h2));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    chk({24'h0, rdata}, {24'h0, exp});
  endtask
  // kind: 0 off, 1 loopback, 2 echo, 3 half-word pair
  task automatic slot_chk(input logic t, input logic [4:0] i, input logic r, input logic [1:0] kind);
    logic [31:0] exp;
    @(posedge mclk_i);
    tdm <= t;
    idx <= i;
    rh <= r;
    stb <= 1'b1;
    #1;
    exp = kind == 2'h1 ? lp : kind == 2'h2 ? ec : kind == 2'h3 ? {h1, h2} : 32'h0;
    @(posedge mclk_i);
    stb <= 1'b0;
    #1;
    chk({31'h0, vld}, 32'h1);
    chk({31'h0, drv}, {31'h0, kind != 2'h0});
    chk(word, exp);
    // valid is a single pulse; word and drive must hold while the sources move on
    @(posedge mclk_i);
    #1;
    chk({31'h0, vld}, 32'h0);
    chk({31'h0, drv}, {31'h0, kind != 2'h0});
    chk(word, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic regs_test();
    rd_chk(8'h23, 8'h05);
    rd_chk(8'h24, 8'h06);
    rd_chk(8'h25, 8'h07);
    wr_reg(8'h23, 8'h7F);
    rd_chk(8'h23, 8'h7F);
    wr_reg(8'h24, 8'h7F);
    rd_chk(8'h24, 8'h7F);
    wr_reg(8'h25, 8'h3F);
    rd_chk(8'h25, 8'h3F);
    rd_chk(8'h30, 8'h00);
    $display("register test done");
  endtask
  task automatic source_test();
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(8'h23, {1'b0, 2'(s), 5'h05});
      slot_chk(1'b1, 5'h05, 1'b0, s == 1 ? 2'h1 : s == 2 ? 2'h2 : 2'h0);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(8'h24, {1'b0, 2'(s), 5'h06});
      slot_chk(1'b1, 5'h06, 1'b0, s == 2 ? 2'h3 : 2'h0);
    end
    $display("source test done");
  endtask
  task automatic slot_test();
    logic [4:0] vals [8] = '{5'h00, 5'h01, 5'h09, 5'h0F, 5'h10, 5'h11, 5'h16, 5'h1F};
    foreach (vals[k])
    begin
      wr_reg(8'h23, {3'b001, vals[k]});
      slot_chk(1'b0, {1'b0, vals[k][3:0]}, vals[k][4], 2'h1);
      slot_chk(1'b0, {1'b0, vals[k][3:0]}, ~vals[k][4], 2'h0);
      slot_chk(1'b1, vals[k], 1'b0, 2'h1);
      slot_chk(1'b1, vals[k] ^ 5'h10, 1'b0, 2'h0);
    end
    $display("slot test done");
  endtask
  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    regs_test();
    source_test();
    slot_test();
    finish_test();
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
